// ---- dsa_bank.sv ----
// Purpose: tracks the open row of one bank
// Assumes: controller activates before column access
// Notes: open wins over close when both come together in one cycle
`timescale 1ns/1ps
`default_nettype none
module dsa_bank (
  input wire logic clk,
  input wire logic rst_n,
  dsa_bank_if.bank bif
);
  logic open_q;
  logic open_d;
  logic [12:0] row_q;
  logic [12:0] row_d;
  assign bif.is_open = open_q;
  assign bif.row = row_q;
  always_comb begin
    open_d = open_q;
    row_d = row_q;
    if (bif.open_req) begin
      open_d = 1'b1;
      row_d = bif.open_row;
    end else if (bif.close_req) begin
      open_d = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      open_q <= 1'b0;
      row_q <= 13'h0;
    end else begin
      open_q <= open_d;
      row_q <= row_d;
    end
  end
endmodule : dsa_bank
`default_nettype wire

// ---- dsa_bank_if.sv ----
// Purpose: carries bank open and close requests to one bank tracker
// Assumes: one driver per bank for each request
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface dsa_bank_if;
  logic open_req;
  logic close_req;
  logic [12:0] open_row;
  logic is_open;
  logic [12:0] row;
  modport ctrl (output open_req, output close_req, output open_row, input is_open, input row);
  modport bank (input open_req, input close_req, input open_row, output is_open, output row);
endinterface : dsa_bank_if
`default_nettype wire

// ---- dsa_ctrl_model.sv ----
// Purpose: controller model driving the dram command and data pins
// Assumes: pins change on the falling clock edge
// Notes: released data and mask show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module dsa_ctrl_model
  import dsa_pkg::*;
(
  // clock
  input wire logic clk,
  // command pins
  output logic cke,
  output logic cs_n,
  output logic [2:0] cmd,
  output logic [dsa_pkg::BANK_W-1:0] ba,
  output logic [dsa_pkg::ADDR_W-1:0] addr,
  // write data
  output logic [2*dsa_pkg::DATA_W-1:0] wdata,
  output logic [2*dsa_pkg::MASK_W-1:0] wmask
);
  initial begin
    cke = 1'b1;
    cs_n = 1'b1;
    cmd = CMD_NOP;
    ba = 2'h0;
    addr = 13'h0;
    wdata = 32'h0;
    wmask = 4'h0;
  end
  // one command cycle, then deselect
  task automatic issue(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a,
                       input logic sel_n, input logic ke);
    @(negedge clk);
    cke = ke;
    cs_n = sel_n;
    cmd = c;
    ba = b;
    addr = a;
    @(negedge clk);
    cs_n = 1'b1;
    cmd = CMD_NOP;
    addr = ~a;
  endtask : issue
  // write data starts one cycle before read data would
  task automatic wr_burst(input logic [1:0] b, input int lat, input int pairs,
                          input logic [15:0] base, input logic [3:0] m);
    issue(CMD_WRITE, b, 13'h010, 1'b0, 1'b1);
    repeat (lat - 1) @(negedge clk);
    // the device registers the command pins before counting
    @(negedge clk);
    for (int k = 0; k < pairs; k++) begin
      wdata = {base + 16'(2 * k + 1), base + 16'(2 * k)};
      wmask = m;
      @(negedge clk);
    end
    wdata = ~wdata;
    wmask = ~wmask;
  endtask : wr_burst
endmodule : dsa_ctrl_model
`default_nettype wire

// ---- dsa_dram_top.sv ----
// Purpose: command decode, banks, latency and burst data path of the dram
// Assumes: REF_CLK is the true clock; data is two beats per clock, rise then fall
// Notes: small memory model; data in and out are per-clock beat pairs
`timescale 1ns/1ps
`default_nettype none
module dsa_dram_top
  import dsa_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // command pins
  input wire logic CLK_EN,
  input wire logic CHIP_SEL_N,
  input wire logic ROW_STROBE_N,
  input wire logic COL_STROBE_N,
  input wire logic WR_STROBE_N,
  input wire logic [dsa_pkg::BANK_W-1:0] BANK_SELECT_BITS,
  input wire logic [dsa_pkg::ADDR_W-1:0] ROW_COLUMN_ADDRESS,
  input wire logic TERMINATION_CONTROL,
  // write data, beat 0 on rise and beat 1 on fall
  input wire logic [2*dsa_pkg::DATA_W-1:0] WR_DATA,
  input wire logic [2*dsa_pkg::MASK_W-1:0] WRITE_BYTE_MASK,
  // read data, beat 0 on rise and beat 1 on fall
  output logic [2*dsa_pkg::DATA_W-1:0] RD_DATA,
  output logic RD_VALID,
  // status
  output logic [dsa_pkg::NUM_BANKS-1:0] BANK_OPEN,
  output logic [1:0] POWER_STATE,
  output logic INPUTS_ENABLED,
  output logic TERM_ENABLED
);
  import dsa_pkg::*;
  // inputs sampled on the rising clock
  logic cke_s;
  logic cs_s;
  logic ras_s;
  logic cas_s;
  logic we_s;
  logic [BANK_W-1:0] ba_s;
  logic [ADDR_W-1:0] a_s;
  logic [2:0] cmd;
  logic live;
  dsa_pwr_t pwr_q;
  dsa_pwr_t pwr_d;
  logic [2:0] cl_q, cl_d, al_q, al_d;
  logic [3:0] bl_q, bl_d;
  logic odt_en_q, odt_en_d;
  logic [DLY_W-1:0] rl, wl;
  logic [NUM_BANKS-1:0] open_vec;
  logic [NUM_BANKS-1:0] op_r, cl_r;
  // pending column command: start delay, kind, bank, column, precharge
  logic pend_q, pend_d, pwr_q_w, pwr_d_w;
  logic [DLY_W-1:0] cnt_q, cnt_d;
  logic [BANK_W-1:0] pb_q, pb_d;
  logic [COL_W-1:0] pc_q, pc_d;
  logic pap_q, pap_d;
  // running burst
  logic bact_q, bact_d, bwr_q, bwr_d;
  logic [3:0] bidx_q, bidx_d;
  logic [BANK_W-1:0] bb_q, bb_d;
  logic [COL_W-1:0] bc_q, bc_d;
  logic bap_q, bap_d;
  logic [2*DATA_W-1:0] rdat_d;
  logic rval_d;
  logic [DATA_W-1:0] mem_q [NUM_BANKS][MEM_DEPTH];
  logic [MEM_IDX_W-1:0] i0, i1;

  // sample on the rising true clock; cke always live, others gated by power
  always_ff @(posedge REF_CLK) begin
    cke_s <= CLK_EN;
    if (INPUTS_ENABLED) begin
      cs_s <= CHIP_SEL_N;
      ras_s <= ROW_STROBE_N;
      cas_s <= COL_STROBE_N;
      we_s <= WR_STROBE_N;
      ba_s <= BANK_SELECT_BITS;
      a_s <= ROW_COLUMN_ADDRESS;
    end else begin
      cs_s <= 1'b1;
      ras_s <= 1'b1;
      cas_s <= 1'b1;
      we_s <= 1'b1;
      ba_s <= '0;
      a_s <= '0;
    end
  end
  assign live = !cs_s && pwr_q == PWR_ON;
  assign cmd = live ? {ras_s, cas_s, we_s} : CMD_NOP;
  assign INPUTS_ENABLED = pwr_q == PWR_ON;
  assign TERM_ENABLED = odt_en_q && TERMINATION_CONTROL && pwr_q != PWR_SELF_REF;
  assign POWER_STATE = pwr_q;
  assign BANK_OPEN = open_vec;
  assign rl = DLY_W'(al_q) + DLY_W'(cl_q);
  assign wl = rl - DLY_W'(1);

  // power state; self refresh exit watches the raw pin level
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      PWR_ON: if (!cke_s) begin
        if (cmd == CMD_REFRESH && open_vec == '0) pwr_d = PWR_SELF_REF;
        else if (open_vec != '0) pwr_d = PWR_ACT_PD;
        else pwr_d = PWR_PRE_PD;
      end
      PWR_ACT_PD, PWR_PRE_PD: if (cke_s) pwr_d = PWR_ON;
      PWR_SELF_REF: if (CLK_EN) pwr_d = PWR_ON;
      default: pwr_d = PWR_ON;
    endcase
  end

  // mode loads and bank control
  always_comb begin
    cl_d = cl_q;
    al_d = al_q;
    bl_d = bl_q;
    odt_en_d = odt_en_q;
    op_r = '0;
    cl_r = '0;
    if (cmd == CMD_MODE && ba_s == MR_SEL) begin
      if (a_s[2:0] == BL4_CODE) bl_d = 4'h4;
      if (a_s[2:0] == BL8_CODE) bl_d = 4'h8;
      if (a_s[6:4] >= CL_MIN && a_s[6:4] <= CL_MAX) cl_d = a_s[6:4];
    end
    if (cmd == CMD_MODE && ba_s == EMR1_SEL) begin
      if (a_s[5:3] <= AL_MAX) al_d = a_s[5:3];
      odt_en_d = a_s[2] | a_s[6];
    end
    if (cmd == CMD_ACTIVATE) op_r[ba_s] = 1'b1;
    if (cmd == CMD_PRECHARGE) begin
      if (a_s[AP_BIT]) cl_r = '1;
      else cl_r[ba_s] = 1'b1;
    end
    if (bact_q && bap_q && bidx_q + 4'h2 >= bl_q) cl_r[bb_q] = 1'b1;
  end

  // four bank trackers
  genvar g;
  for (g = 0; g < NUM_BANKS; g++) begin : g_bank
    dsa_bank_if bif ();
    assign bif.open_req = op_r[g];
    assign bif.close_req = cl_r[g];
    assign bif.open_row = a_s;
    assign open_vec[g] = bif.is_open;
    dsa_bank u_bank (.clk(REF_CLK), .rst_n(RST_N), .bif(bif));
  end

  // posted column command, then burst
  always_comb begin
    pend_d = pend_q;
    pwr_d_w = pwr_q_w;
    cnt_d = cnt_q;
    pb_d = pb_q;
    pc_d = pc_q;
    pap_d = pap_q;
    bact_d = bact_q;
    bwr_d = bwr_q;
    bidx_d = bidx_q;
    bb_d = bb_q;
    bc_d = bc_q;
    bap_d = bap_q;
    if (cmd == CMD_READ || cmd == CMD_WRITE) begin
      pend_d = 1'b1;
      pwr_d_w = cmd == CMD_WRITE;
      cnt_d = (cmd == CMD_WRITE) ? wl : rl;
      pb_d = ba_s;
      pc_d = a_s[COL_W-1:0];
      pap_d = a_s[AP_BIT];
    end else if (pend_q) begin
      if (cnt_q <= DLY_W'(1)) begin
        pend_d = 1'b0;
        bact_d = 1'b1;
        bwr_d = pwr_q_w;
        bidx_d = 4'h0;
        bb_d = pb_q;
        bc_d = pc_q;
        bap_d = pap_q;
      end else begin
        cnt_d = cnt_q - DLY_W'(1);
      end
    end
    if (bact_q && !(pend_q && cnt_q <= DLY_W'(1))) begin
      bidx_d = bidx_q + 4'h2;
      if (bidx_q + 4'h2 >= bl_q) bact_d = 1'b0;
    end
  end

  // sequential order within the burst block, wrapping at burst length
  always_comb begin
    logic [3:0] m;
    m = bl_q - 4'h1;
    i0 = MEM_IDX_W'((bc_q & ~COL_W'(m)) | COL_W'((bc_q[3:0] + bidx_q) & m));
    i1 = MEM_IDX_W'((bc_q & ~COL_W'(m)) | COL_W'((bc_q[3:0] + bidx_q + 4'h1) & m));
    rval_d = bact_q && !bwr_q;
    rdat_d = rval_d ? {mem_q[bb_q][i1], mem_q[bb_q][i0]} : '0;
  end

  always_ff @(posedge REF_CLK) begin
    if (bact_q && bwr_q) begin
      if (!WRITE_BYTE_MASK[0]) mem_q[bb_q][i0][7:0] <= WR_DATA[7:0];
      if (!WRITE_BYTE_MASK[1]) mem_q[bb_q][i0][15:8] <= WR_DATA[15:8];
      if (!WRITE_BYTE_MASK[2]) mem_q[bb_q][i1][7:0] <= WR_DATA[23:16];
      if (!WRITE_BYTE_MASK[3]) mem_q[bb_q][i1][15:8] <= WR_DATA[31:24];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      pwr_q <= PWR_ON;
      cl_q <= CL_RESET;
      al_q <= AL_RESET;
      bl_q <= BL_RESET;
      odt_en_q <= 1'b0;
      pend_q <= 1'b0;
      pwr_q_w <= 1'b0;
      cnt_q <= '0;
      pb_q <= '0;
      pc_q <= '0;
      pap_q <= 1'b0;
      bact_q <= 1'b0;
      bwr_q <= 1'b0;
      bidx_q <= 4'h0;
      bb_q <= '0;
      bc_q <= '0;
      bap_q <= 1'b0;
      RD_DATA <= '0;
      RD_VALID <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      cl_q <= cl_d;
      al_q <= al_d;
      bl_q <= bl_d;
      odt_en_q <= odt_en_d;
      pend_q <= pend_d;
      pwr_q_w <= pwr_d_w;
      cnt_q <= cnt_d;
      pb_q <= pb_d;
      pc_q <= pc_d;
      pap_q <= pap_d;
      bact_q <= bact_d;
      bwr_q <= bwr_d;
      bidx_q <= bidx_d;
      bb_q <= bb_d;
      bc_q <= bc_d;
      bap_q <= bap_d;
      RD_DATA <= rdat_d;
      RD_VALID <= rval_d;
    end
  end
endmodule : dsa_dram_top
`default_nettype wire

// ---- dsa_dram_top_asserts.sv ----
// Purpose: port assertions for the dram access interface
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to the top module
`timescale 1ns/1ps
`default_nettype none
module dsa_dram_top_asserts
  import dsa_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // command pins
  input wire logic CLK_EN,
  input wire logic CHIP_SEL_N,
  input wire logic ROW_STROBE_N,
  input wire logic COL_STROBE_N,
  input wire logic WR_STROBE_N,
  input wire logic [dsa_pkg::BANK_W-1:0] BANK_SELECT_BITS,
  // status
  input wire logic RD_VALID,
  input wire logic [dsa_pkg::NUM_BANKS-1:0] BANK_OPEN,
  input wire logic [1:0] POWER_STATE,
  input wire logic INPUTS_ENABLED,
  input wire logic TERM_ENABLED
);
  logic act_c;
  logic rd_c;
  assign act_c = !CHIP_SEL_N && {ROW_STROBE_N, COL_STROBE_N, WR_STROBE_N} == CMD_ACTIVATE;
  assign rd_c = !CHIP_SEL_N && {ROW_STROBE_N, COL_STROBE_N, WR_STROBE_N} == CMD_READ;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  sequence burst4_s; RD_VALID [*2] ##1 !RD_VALID; endsequence
  sequence burst8_s; RD_VALID [*4] ##1 !RD_VALID; endsequence
  bank_open_cause_a: assert property ((BANK_OPEN & ~$past(BANK_OPEN)) != 4'h0 |->
    ($past(act_c) && (BANK_OPEN & ~$past(BANK_OPEN)) == 4'h1 << $past(BANK_SELECT_BITS)) ||
    ($past(act_c, 2) && (BANK_OPEN & ~$past(BANK_OPEN)) == 4'h1 << $past(BANK_SELECT_BITS, 2)))
    else $error("bank opened without activate");
  burst_len_a: assert property ($rose(RD_VALID) |-> burst4_s or burst8_s)
    else $error("read burst length wrong");
  rd_answer_a: assert property (rd_c && POWER_STATE == 2'h0 |-> ##[6:16] RD_VALID)
    else $error("read gave no data");
  pd_entry_a: assert property (POWER_STATE != 2'h0 && $past(POWER_STATE) == 2'h0 |->
    !$past(CLK_EN) || !$past(CLK_EN, 2)) else $error("power-down without clock enable low");
  pd_kind_a: assert property (POWER_STATE != 2'h0 |->
    (POWER_STATE == 2'h1) == (BANK_OPEN != 4'h0)) else $error("power-down kind wrong");
  buf_gate_a: assert property (INPUTS_ENABLED == (POWER_STATE == 2'h0))
    else $error("input buffers not gated");
  sr_term_a: assert property (POWER_STATE == 2'h3 |-> !TERM_ENABLED)
    else $error("termination on in self refresh");
  pd_exit_a: assert property (POWER_STATE != 2'h0 && CLK_EN |-> ##[1:3] POWER_STATE == 2'h0)
    else $error("no wake on clock enable");
endmodule : dsa_dram_top_asserts
bind dsa_dram_top dsa_dram_top_asserts u_asserts (.REF_CLK(REF_CLK), .RST_N(RST_N),
  .CLK_EN(CLK_EN), .CHIP_SEL_N(CHIP_SEL_N), .ROW_STROBE_N(ROW_STROBE_N),
  .COL_STROBE_N(COL_STROBE_N), .WR_STROBE_N(WR_STROBE_N), .BANK_SELECT_BITS(BANK_SELECT_BITS),
  .RD_VALID(RD_VALID), .BANK_OPEN(BANK_OPEN), .POWER_STATE(POWER_STATE),
  .INPUTS_ENABLED(INPUTS_ENABLED), .TERM_ENABLED(TERM_ENABLED));
`default_nettype wire

// ---- dsa_dram_top_tb.sv ----
// Purpose: self-checking bench for the dram access interface
// Assumes: 50 MHz clock, inputs change on the falling edge
// Notes: each scenario task judges its own results
`timescale 1ns/1ps
`default_nettype none
module dsa_dram_top_tb;
  import dsa_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cke, cs_n, rd_valid, in_en, term_en;
  logic [2:0] cmd;
  logic [1:0] ba, pwr;
  logic [12:0] addr;
  logic [31:0] wdata, rd_data;
  logic [3:0] wmask, bank_open;
  logic termination_control = 1'b1;
  int error_cnt = 0;
  int num_checks = 0;
  always #10 ref_clk = ~ref_clk;
  dsa_ctrl_model m (.clk(ref_clk), .cke(cke), .cs_n(cs_n), .cmd(cmd), .ba(ba), .addr(addr),
    .wdata(wdata), .wmask(wmask));
  dsa_dram_top DUT (.REF_CLK(ref_clk), .RST_N(rst_n), .CLK_EN(cke), .CHIP_SEL_N(cs_n),
    .ROW_STROBE_N(cmd[2]), .COL_STROBE_N(cmd[1]), .WR_STROBE_N(cmd[0]), .BANK_SELECT_BITS(ba),
    .ROW_COLUMN_ADDRESS(addr), .TERMINATION_CONTROL(termination_control), .WR_DATA(wdata),
    .WRITE_BYTE_MASK(wmask), .RD_DATA(rd_data), .RD_VALID(rd_valid), .BANK_OPEN(bank_open),
    .POWER_STATE(pwr), .INPUTS_ENABLED(in_en), .TERM_ENABLED(term_en));
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic settle();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : settle
  // masked bytes keep the first write
  function automatic logic [15:0] mrg(input logic [15:0] a, input logic [15:0] b, input int s);
    return (s % 2) ? {b[15:8], a[7:0]} : {a[15:8], b[7:0]};
  endfunction : mrg
  task automatic t_access(input logic [1:0] b, input int cl, input int al, input int bl,
                          input logic ap);
    int cnt;
    int s;
    logic [15:0] a0;
    logic [15:0] b0;
    cnt = 0;
    a0 = {2'h0, b, 12'h100};
    b0 = {2'h0, b, 12'h200};
    m.issue(CMD_MODE, MR_SEL, 13'(cl * 16 + (bl == 8 ? 3 : 2)), 1'b0, 1'b1);
    m.issue(CMD_MODE, EMR1_SEL, 13'(al * 8 + 4), 1'b0, 1'b1);
    m.issue(CMD_ACTIVATE, b, 13'h1abc, 1'b0, 1'b1);
    m.wr_burst(b, cl + al, bl / 2, a0, 4'h0);
    m.wr_burst(b, cl + al, bl / 2, b0, 4'h6);
    m.issue(CMD_READ, b, {2'h0, ap, 10'h012}, 1'b0, 1'b1);
    while (rd_valid !== 1'b1 && cnt < 20) begin
      @(posedge ref_clk);
      #1;
      cnt++;
    end
    // pin register and output register add one cycle each
    chk(32'(cnt), 32'(cl + al + 2));
    if (cnt >= 20) complete_run();
    for (int j = 0; j < bl; j += 2) begin
      s = (j + 2) % bl;
      chk(rd_data, {mrg(a0 + 16'(s + 1), b0 + 16'(s + 1), s + 1),
        mrg(a0 + 16'(s), b0 + 16'(s), s)});
      @(posedge ref_clk);
      #1;
    end
    settle();
    chk(32'({term_en, bank_open[b]}), 32'({1'b1, ~ap}));
  endtask : t_access
  task automatic t_close();
    chk(32'(bank_open), 32'hf);
    m.issue(CMD_PRECHARGE, 2'h1, 13'h0, 1'b0, 1'b1);
    settle();
    chk(32'(bank_open), 32'hd);
    m.issue(CMD_PRECHARGE, 2'h0, 13'h400, 1'b0, 1'b1);
    settle();
    chk(32'(bank_open), 32'h0);
    m.issue(CMD_ACTIVATE, 2'h2, 13'h0, 1'b1, 1'b1);
    settle();
    chk(32'(bank_open), 32'h0);
    @(negedge ref_clk);
    termination_control = 1'b0;
    #1;
    chk(32'(term_en), 32'h0);
    @(negedge ref_clk);
    termination_control = 1'b1;
  endtask : t_close
  task automatic t_pwr(input logic [2:0] c, input logic [1:0] st);
    m.issue(c, 2'h0, 13'h0, 1'b0, 1'b0);
    settle();
    chk(32'({pwr, in_en, term_en}), 32'({st, 1'b0, st != 2'h3}));
    m.issue(CMD_NOP, 2'h0, 13'h0, 1'b1, 1'b1);
    settle();
    chk(32'({pwr, in_en}), 32'({2'h0, 1'b1}));
  endtask : t_pwr
  initial begin
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    t_access(2'h0, 3, 0, 4, 1'b0);
    t_access(2'h1, 5, 2, 8, 1'b0);
    t_access(2'h2, 7, 6, 8, 1'b0);
    t_access(2'h3, 4, 1, 4, 1'b1);
    t_access(2'h3, 6, 3, 4, 1'b0);
    t_close();
    t_pwr(CMD_NOP, 2'h2);
    m.issue(CMD_ACTIVATE, 2'h0, 13'h0, 1'b0, 1'b1);
    t_pwr(CMD_NOP, 2'h1);
    m.issue(CMD_PRECHARGE, 2'h0, 13'h400, 1'b0, 1'b1);
    t_pwr(CMD_REFRESH, 2'h3);
    complete_run();
  end
endmodule : dsa_dram_top_tb
`default_nettype wire

// ---- dsa_pkg.sv ----
// Purpose: shared constants and types for the dram access interface
// Assumes: x16 data, four banks, 13 row bits, 9 column bits
// Notes: one clock domain, the controller clock REF_CLK
package dsa_pkg;
  localparam int unsigned BANK_W = 2;
  localparam int unsigned NUM_BANKS = 4;
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned COL_W = 9;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned MASK_W = 2;
  localparam int unsigned AP_BIT = 10;
  localparam int unsigned MEM_DEPTH = 64;
  localparam int unsigned MEM_IDX_W = 6;
  localparam int unsigned DLY_W = 5;
  localparam logic [2:0] BL_FIELD_LSB = 3'h0;
  localparam logic [3:0] CL_FIELD_LSB = 4'h4;
  localparam logic [3:0] AL_FIELD_LSB = 4'h3;
  localparam logic [2:0] BL4_CODE = 3'h2;
  localparam logic [2:0] BL8_CODE = 3'h3;
  localparam logic [2:0] CL_MIN = 3'h3;
  localparam logic [2:0] CL_MAX = 3'h7;
  localparam logic [2:0] AL_MAX = 3'h6;
  localparam logic [2:0] CL_RESET = 3'h3;
  localparam logic [2:0] AL_RESET = 3'h0;
  localparam logic [3:0] BL_RESET = 4'h4;
  localparam logic [1:0] MR_SEL = 2'h0;
  localparam logic [1:0] EMR1_SEL = 2'h1;
  localparam logic [2:0] CMD_MODE = 3'h0;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_ACTIVATE = 3'h3;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_NOP = 3'h7;
  typedef enum logic [1:0] {PWR_ON, PWR_ACT_PD, PWR_PRE_PD, PWR_SELF_REF} dsa_pwr_t;
endpackage : dsa_pkg
